//--- include/rsx_pkg.sv
// Purpose: shared types and constants for the rotate/subtract/xor datapath
// Assumes: 8-bit data, 7-bit register addresses
// Notes:   operation codes are local to this block
package rsx_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int NIB_W = 4;
  localparam int MSB = 7;
  localparam int LSB = 0;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
  localparam logic [DATA_W-1:0] WDT_CLEAR = 8'h00;
  localparam logic [DATA_W-1:0] PRESC_CLEAR = 8'h00;
  localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
  localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
  localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;
  localparam logic TARGET_ACC = 1'b0;
  localparam logic TARGET_REG = 1'b1;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_LITERAL_MINUS_ACC,
    OP_REG_MINUS_ACC,
    OP_REG_MINUS_ACC_BORROW,
    OP_NIBBLE_EXCHANGE,
    OP_XOR_IMMEDIATE,
    OP_XOR_REGISTER,
    OP_LOAD_DIRECTION_REG,
    OP_SLEEP
  } rsx_op_type;

  typedef struct packed {
    rsx_op_type          op;
    logic [ADDR_W-1:0]   operand_address;
    logic [DATA_W-1:0]   immediate_byte;
    logic                target_select;
  } rsx_instr_type;

  typedef struct packed {
    logic carry;
    logic nibble_borrow_inverse;
    logic zero;
    logic watchdog_expiry_flag_n;
    logic powerdown_flag_n;
  } rsx_status_type;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic              carry;
    logic              nibble;
  } rsx_sub_type;

endpackage : rsx_pkg

//--- logic/rsx_subtractor.sv
// Purpose: 8-bit subtractor with carry/nibble-carry as not-borrow
// Assumes: borrow_n high means no borrow pending
// Notes:   purely combinational
`timescale 1ns/1ps
module rsx_subtractor
  import rsx_pkg::*;
(
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  input  wire logic              borrow_n,
  output rsx_sub_type            diff
);

  logic [DATA_W:0]  full;
  logic [NIB_W:0]   low;

  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DATA_W{1'b0}}, borrow_n};
    low  = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~subtrahend[NIB_W-1:0]}
         + {{NIB_W{1'b0}}, borrow_n};
    diff.result = full[DATA_W-1:0];
    diff.carry  = full[DATA_W];
    diff.nibble = low[NIB_W];
  end

endmodule // rsx_subtractor

//--- logic/rsx_datapath.sv
// Purpose: execute rotate, subtract, swap, xor, direction-load and sleep
// Assumes: one instruction per instr_valid pulse; decode done upstream
// Notes:   register file held here as flip-flops
`timescale 1ns/1ps

// Contract
// - rotate right through carry, carry only
// - target select: 0 accumulator, 1 register
// - literal minus accumulator into accumulator
// - subtract sets carry, nibble carry, zero
// - register minus accumulator to destination
// - register minus accumulator minus inverted carry
// - sleep clears watchdog, prescaler; sets watchdog_expiry_flag_n, clears powerdown_flag_n
// - sleep halts oscillator, enters sleep state
// - nibble exchange, no flags changed
// - xor immediate into accumulator, zero only
// - xor register to destination, zero only
// - load direction register 5/6/7 ports
// - 7-bit address, 8-bit literal operands
// - rotate left through carry, carry only
module rsx_datapath
  import rsx_pkg::*;
#(
  parameter int DEPTH = FILE_DEPTH
)
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                instr_valid,
  input  rsx_instr_type            instr,
  input  wire logic                wake,
  output logic [DATA_W-1:0]        accumulator,
  output rsx_status_type           status,
  output logic [DATA_W-1:0]        port_a_direction,
  output logic [DATA_W-1:0]        port_b_direction,
  output logic [DATA_W-1:0]        port_c_direction,
  output logic [DATA_W-1:0]        watchdog_counter,
  output logic [DATA_W-1:0]        watchdog_prescaler,
  output logic                     sleep_active,
  output logic                     oscillator_run,
  output logic [DATA_W-1:0]        read_data
);

  typedef enum logic {
    ST_RUN,
    ST_SLEEP
  } rsx_state_type;

  logic [DATA_W-1:0] file_q [DEPTH];
  logic [DATA_W-1:0] file_d [DEPTH];
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  rsx_status_type    stat_q;
  rsx_status_type    stat_d;
  logic [DATA_W-1:0] dir_a_q;
  logic [DATA_W-1:0] dir_a_d;
  logic [DATA_W-1:0] dir_b_q;
  logic [DATA_W-1:0] dir_b_d;
  logic [DATA_W-1:0] dir_c_q;
  logic [DATA_W-1:0] dir_c_d;
  logic [DATA_W-1:0] wdt_q;
  logic [DATA_W-1:0] wdt_d;
  logic [DATA_W-1:0] presc_q;
  logic [DATA_W-1:0] presc_d;
  rsx_state_type     state_q;
  rsx_state_type     state_d;
  logic              osc_q;
  logic              osc_d;
  logic              sleep_q;
  logic              sleep_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic [DATA_W-1:0] reg_value;
  logic [DATA_W-1:0] sub_minuend;
  logic              sub_borrow_n;
  rsx_sub_type       sub_out;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == ZERO_BYTE;
  endfunction

  assign reg_value = file_q[instr.operand_address];

  always_comb begin
    sub_minuend  = reg_value;
    sub_borrow_n = 1'b1;
    case (instr.op)
      OP_LITERAL_MINUS_ACC: sub_minuend = instr.immediate_byte;
      OP_REG_MINUS_ACC_BORROW: sub_borrow_n = stat_q.carry;
      default: begin
        sub_minuend  = reg_value;
        sub_borrow_n = 1'b1;
      end
    endcase
  end

  rsx_subtractor u_sub (
    .minuend    (sub_minuend),
    .subtrahend (acc_q),
    .borrow_n   (sub_borrow_n),
    .diff       (sub_out)
  );

  always_comb begin
    logic [DATA_W-1:0] res;
    logic              to_dest;
    logic              upd_zero;
    res      = ZERO_BYTE;
    to_dest  = 1'b0;
    upd_zero = 1'b0;
    file_d   = file_q;
    acc_d    = acc_q;
    stat_d   = stat_q;
    dir_a_d  = dir_a_q;
    dir_b_d  = dir_b_q;
    dir_c_d  = dir_c_q;
    wdt_d    = wdt_q;
    presc_d  = presc_q;
    state_d  = state_q;
    osc_d    = osc_q;
    rdata_d  = reg_value;
    case (state_q)
      ST_RUN: begin
        if (instr_valid) begin
          case (instr.op)
            OP_ROTATE_RIGHT_VIA_CARRY: begin
              res          = {stat_q.carry, reg_value[MSB:LSB+1]};
              stat_d.carry = reg_value[LSB];
              to_dest      = 1'b1;
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
              res          = {reg_value[MSB-1:LSB], stat_q.carry};
              stat_d.carry = reg_value[MSB];
              to_dest      = 1'b1;
            end
            OP_LITERAL_MINUS_ACC: begin
              acc_d                        = sub_out.result;
              stat_d.carry                 = sub_out.carry;
              stat_d.nibble_borrow_inverse = sub_out.nibble;
              res                          = sub_out.result;
              upd_zero                     = 1'b1;
            end
            OP_REG_MINUS_ACC, OP_REG_MINUS_ACC_BORROW: begin
              res                          = sub_out.result;
              stat_d.carry                 = sub_out.carry;
              stat_d.nibble_borrow_inverse = sub_out.nibble;
              upd_zero                     = 1'b1;
              to_dest                      = 1'b1;
            end
            OP_NIBBLE_EXCHANGE: begin
              res     = {reg_value[NIB_W-1:0], reg_value[DATA_W-1:NIB_W]};
              to_dest = 1'b1;
            end
            OP_XOR_IMMEDIATE: begin
              res      = acc_q ^ instr.immediate_byte;
              acc_d    = res;
              upd_zero = 1'b1;
            end
            OP_XOR_REGISTER: begin
              res      = acc_q ^ reg_value;
              upd_zero = 1'b1;
              to_dest  = 1'b1;
            end
            OP_LOAD_DIRECTION_REG: begin
              case (instr.operand_address)
                DIR_SEL_A: dir_a_d = acc_q;
                DIR_SEL_B: dir_b_d = acc_q;
                DIR_SEL_C: dir_c_d = acc_q;
                default: dir_a_d = dir_a_q;
              endcase
            end
            OP_SLEEP: begin
              wdt_d                         = WDT_CLEAR;
              presc_d                       = PRESC_CLEAR;
              stat_d.watchdog_expiry_flag_n = 1'b1;
              stat_d.powerdown_flag_n       = 1'b0;
              state_d                       = ST_SLEEP;
              osc_d                         = 1'b0;
            end
            default: res = ZERO_BYTE;
          endcase
          if (to_dest) begin
            if (instr.target_select == TARGET_REG) begin
              file_d[instr.operand_address] = res;
            end else begin
              acc_d = res;
            end
          end
          if (upd_zero) begin
            stat_d.zero = is_zero(res);
          end
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_d = ST_RUN;
          osc_d   = 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
        osc_d   = 1'b1;
      end
    endcase
    // sleep flag registered beside the state
    sleep_d = (state_d == ST_SLEEP);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        file_q[i] <= ZERO_BYTE;
      end
      acc_q   <= ZERO_BYTE;
      stat_q  <= '{carry: 1'b0, nibble_borrow_inverse: 1'b0, zero: 1'b0,
                   watchdog_expiry_flag_n: 1'b1, powerdown_flag_n: 1'b1};
      dir_a_q <= DIR_RESET;
      dir_b_q <= DIR_RESET;
      dir_c_q <= DIR_RESET;
      wdt_q   <= WDT_CLEAR;
      presc_q <= PRESC_CLEAR;
      state_q <= ST_RUN;
      osc_q   <= 1'b1;
      sleep_q <= 1'b0;
      rdata_q <= ZERO_BYTE;
    end else begin
      file_q  <= file_d;
      acc_q   <= acc_d;
      stat_q  <= stat_d;
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
      dir_c_q <= dir_c_d;
      wdt_q   <= wdt_d;
      presc_q <= presc_d;
      state_q <= state_d;
      osc_q   <= osc_d;
      sleep_q <= sleep_d;
      rdata_q <= rdata_d;
    end
  end

  assign accumulator        = acc_q;
  assign status             = stat_q;
  assign port_a_direction   = dir_a_q;
  assign port_b_direction   = dir_b_q;
  assign port_c_direction   = dir_c_q;
  assign watchdog_counter   = wdt_q;
  assign watchdog_prescaler = presc_q;
  assign sleep_active       = sleep_q;
  assign oscillator_run     = osc_q;
  assign read_data          = rdata_q;

endmodule // rsx_datapath

//--- tb/rsx_datapath_asserts.sv
// Purpose: port-level timing checks for the datapath
// Assumes: one clock, async active-high reset
// Notes:   file contents are left to the bench model
`timescale 1ns/1ps
module rsx_datapath_asserts
  import rsx_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              instr_valid,
  input rsx_instr_type          instr,
  input wire logic              wake,
  input wire logic [DATA_W-1:0] accumulator,
  input rsx_status_type         status,
  input wire logic [DATA_W-1:0] port_a_direction,
  input wire logic [DATA_W-1:0] port_b_direction,
  input wire logic [DATA_W-1:0] port_c_direction,
  input wire logic [DATA_W-1:0] watchdog_counter,
  input wire logic [DATA_W-1:0] watchdog_prescaler,
  input wire logic              sleep_active,
  input wire logic              oscillator_run,
  input wire logic [DATA_W-1:0] read_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire tk = instr_valid && !sleep_active;
  wire to_acc = instr.target_select == TARGET_ACC;

  rot_right_a: assert property (
    tk && instr.op == OP_ROTATE_RIGHT_VIA_CARRY && to_acc
    |=> accumulator[MSB] == $past(status.carry) && $stable(status[3:0]))
    else $error("rotate right result wrong");
  rot_left_a: assert property (
    tk && instr.op == OP_ROTATE_LEFT_VIA_CARRY && to_acc
    |=> accumulator[LSB] == $past(status.carry) && $stable(status[3:0]))
    else $error("rotate left result wrong");
  lit_sub_a: assert property (
    tk && instr.op == OP_LITERAL_MINUS_ACC
    |=> accumulator == DATA_W'($past(instr.immediate_byte) - $past(accumulator))
    && status.carry == ($past(accumulator) <= $past(instr.immediate_byte))
    && status.nibble_borrow_inverse
       == ($past(accumulator[3:0]) <= $past(instr.immediate_byte[3:0])))
    else $error("literal subtract wrong");
  xor_imm_a: assert property (
    tk && instr.op == OP_XOR_IMMEDIATE
    |=> accumulator == ($past(accumulator) ^ $past(instr.immediate_byte))
    && status.zero == (accumulator == ZERO_BYTE) && $stable(status.carry))
    else $error("xor immediate wrong");
  target_reg_a: assert property (
    tk && instr.op == OP_XOR_REGISTER && !to_acc |=> $stable(accumulator))
    else $error("register target touched accumulator");
  swap_flags_a: assert property (
    tk && instr.op == OP_NIBBLE_EXCHANGE |=> $stable(status))
    else $error("swap changed status");
  dir_load_a: assert property (
    tk && instr.op == OP_LOAD_DIRECTION_REG && instr.operand_address == DIR_SEL_B
    |=> port_b_direction == $past(accumulator) && $stable(status))
    else $error("direction load wrong");
  sleep_entry_a: assert property (
    tk && instr.op == OP_SLEEP |=> watchdog_counter == WDT_CLEAR
    && watchdog_prescaler == PRESC_CLEAR
    && status.watchdog_expiry_flag_n && !status.powerdown_flag_n)
    else $error("sleep entry flags wrong");
  sleep_halt_a: assert property (
    tk && instr.op == OP_SLEEP |=> (sleep_active && !oscillator_run) [*2])
    else $error("sleep did not halt");

  cover property (tk && instr.op == OP_SLEEP);
  cover property (tk && instr.op == OP_LITERAL_MINUS_ACC ##1 status.zero);
  cover property (tk && instr.op == OP_REG_MINUS_ACC_BORROW && !status.carry);
endmodule // rsx_datapath_asserts

//--- tb/cpu_rotate_subtract_xor_ops_bench.sv
// Purpose: self-checking bench against an integer model
// Assumes: one instruction every third cycle
// Notes:   file observed through read_data after each step
`timescale 1ns/1ps
module cpu_rotate_subtract_xor_ops_bench
  import rsx_pkg::*;
;
  logic           clock = 0;
  logic           reset = 1;
  logic           instr_valid = 0;
  logic           wake = 0;
  rsx_instr_type  instr = '0;
  rsx_status_type st;
  logic [7:0]     acc, pa, pb, pc, wdt, presc, rd;
  logic           slp, osc;
  int             n_fail = 0;
  int             comparisons = 0;
  int             mf[128];
  int             md[3] = '{255, 255, 255};
  int             ma = 0, mc = 0, mdc = 0, mz = 0, mpd = 1, msl = 0;

  rsx_datapath i_rsx_datapath (.clock, .reset, .instr_valid, .instr, .wake,
    .accumulator(acc), .status(st), .port_a_direction(pa), .port_b_direction(pb),
    .port_c_direction(pc), .watchdog_counter(wdt), .watchdog_prescaler(presc),
    .sleep_active(slp), .oscillator_run(osc), .read_data(rd));

  always #2.5 clock = ~clock;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic run(input rsx_op_type op, input int a, input int k, input int t);
    int s, r, b;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= '{op, a[6:0], k[7:0], t[0]};
    @(posedge clock);
    instr_valid <= 1'b0;
    instr.op <= OP_NONE;
    if (msl) op = OP_NONE;
    s = (op inside {OP_LITERAL_MINUS_ACC, OP_XOR_IMMEDIATE}) ? k : mf[a];
    r = 0;
    case (op)
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        r = (mc << 7) | (s >> 1);
        mc = s & 1;
      end
      OP_ROTATE_LEFT_VIA_CARRY: begin
        r = ((s << 1) | mc) & 255;
        mc = s >> 7;
      end
      OP_LITERAL_MINUS_ACC, OP_REG_MINUS_ACC, OP_REG_MINUS_ACC_BORROW: begin
        b = (op == OP_REG_MINUS_ACC_BORROW) ? 1 - mc : 0;
        r = (s - ma - b) & 255;
        mc = s >= ma + b;
        mdc = (s & 15) >= (ma & 15) + b;
        mz = r == 0;
      end
      OP_NIBBLE_EXCHANGE: r = ((s << 4) | (s >> 4)) & 255;
      OP_XOR_IMMEDIATE, OP_XOR_REGISTER: begin
        r = ma ^ s;
        mz = r == 0;
      end
      OP_LOAD_DIRECTION_REG: if (a >= 5 && a <= 7) md[a-5] = ma;
      OP_SLEEP: begin
        mpd = 0;
        msl = 1;
      end
      default: ;
    endcase
    if (op inside {OP_LITERAL_MINUS_ACC, OP_XOR_IMMEDIATE}) ma = r;
    else if (op inside {[OP_ROTATE_RIGHT_VIA_CARRY:OP_XOR_REGISTER]}) begin
      if (t) mf[a] = r;
      else ma = r;
    end
    @(posedge clock);
    #1;
    chk_byte(acc, ma[7:0]);
    chk_byte(rd, mf[a][7:0]);
    chk_flags(st, {mc[0], mdc[0], mz[0], 1'b1, mpd[0]});
    chk_byte(pa, md[0][7:0]);
    chk_byte(pb, md[1][7:0]);
    chk_byte(pc, md[2][7:0]);
  endtask

  initial begin
    repeat (50000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial begin
    int k;
    k = $urandom(29092);
    foreach (mf[i]) mf[i] = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    run(OP_XOR_IMMEDIATE, 3, 8'h5a, 0);
    run(OP_LITERAL_MINUS_ACC, 3, 8'h5a, 0);
    run(OP_XOR_IMMEDIATE, 3, 8'h01, 0);
    run(OP_REG_MINUS_ACC_BORROW, 3, 8'h00, 1);
    for (int i = 4; i <= 8; i++) run(OP_LOAD_DIRECTION_REG, i, 8'h00, 0);
    run(OP_XOR_REGISTER, 127, 8'h00, 1);
    run(OP_ROTATE_RIGHT_VIA_CARRY, 127, 8'h00, 1);
    $display("directed test done");
    repeat (400) run(rsx_op_type'(1 + $urandom % 9), $urandom % 16, $urandom % 256,
                     $urandom % 2);
    $display("random test done");
    run(OP_SLEEP, 0, 8'h00, 0);
    chk_byte(wdt, 8'h00);
    chk_byte(presc, 8'h00);
    chk_flags({3'h0, slp, osc}, 5'h02);
    run(OP_XOR_IMMEDIATE, 0, 8'hff, 0);
    @(posedge clock);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
    msl = 0;
    @(posedge clock);
    #1;
    chk_flags({3'h0, slp, osc}, 5'h01);
    run(OP_XOR_IMMEDIATE, 0, 8'hff, 0);
    $display("sleep test done");
    conclude();
  end
endmodule // cpu_rotate_subtract_xor_ops_bench

bind rsx_datapath rsx_datapath_asserts i_rsx_datapath_asserts (.clock, .reset,
  .instr_valid, .instr, .wake, .accumulator, .status, .port_a_direction,
  .port_b_direction, .port_c_direction, .watchdog_counter, .watchdog_prescaler,
  .sleep_active, .oscillator_run, .read_data);
